// >>> ics_osc_switch.sv
// ics_osc_switch: system clock source selection and glitch-free switching
//Contract
// RULE1: fast internal oscillator runs at 16 MHz and feeds a postscaler.
// RULE2: slow internal oscillator runs at 31 kHz, bypassing the postscaler.
// RULE3: fast oscillator on for fast frequency with config 100 or source 1x.
// RULE4: slow oscillator on for 000 with source 1x, or for timers and monitor.
// RULE5: fast ready status set while the fast oscillator runs.
// RULE6: fast stable status set once within 0.5 percent of final frequency.
// RULE7: slow ready status set while the slow oscillator runs.
// RULE8: frequency select picks 16 MHz to 31.25 kHz, or 31 kHz slow.
// RULE9: reset loads frequency select with 0111, giving 500 kHz.
// RULE10: duplicate frequency encodings each use their own oscillator; here both encodings take the same fast oscillator tap.
// RULE11: a shut-down target oscillator gets a start-up delay first.
// RULE12: wait current falling edge, hold low, wait new rising edge.
// RULE13: same-oscillator frequency changes take no start-up delay.
// RULE14: status always shows which internal oscillators are active.
// RULE15: source select 00 uses the default oscillator configuration.
// RULE16: source select 01 uses the secondary crystal oscillator.
// RULE17: source select 1x uses the internal block at selected frequency.
// RULE18: source select clears on every reset.
// RULE19: automatic switches leave the source select field unchanged.
// RULE20: start-up timer status set on external source after timer expiry.
// RULE21: secondary oscillator runs only while its enable bit is set.
// RULE22: software waits for secondary ready before selecting source 01.
// RULE23: internal mode frees clock-in pin; clock-out pin per enable bit.
// RULE24: switch costs one cycle each to slow, about 2 us to fast.
// RULE25: a new selection during a pending switch restarts the sequence.
//
// The plain strobed port and the address map are this design's own decisions.
module ics_osc_switch
    import ics_pkg::*;
#(
    parameter int FAST_START = FAST_START_CYC,
    parameter int FAST_STAB  = FAST_STABLE_CYC,
    parameter int SLOW_HALF  = SLOW_HALF_CYC,
    parameter int OST_COUNT  = OST_EDGES,
    parameter int SEC_COUNT  = SEC_READY_EDGES
) (
    input  wire logic       clk,                  // 20 MHz system clock
    input  wire logic       rst_n,                // async reset, active low
    input  wire logic [1:0] reg_addr,             // register word index
    input  wire logic [7:0] reg_wdata,            // register write data
    input  wire logic       reg_wr,               // write strobe
    input  wire logic       reg_rd,               // read strobe
    output logic      [7:0] reg_rdata,            // read data, next cycle
    input  wire logic [2:0] default_osc_config,   // configured default osc
    input  wire logic       clock_out_enable,     // clock-out pin function
    input  wire logic       powerup_timer_active, // power-up timer running
    input  wire logic       watchdog_enable,      // watchdog needs slow osc
    input  wire logic       failsafe_enable,      // monitor needs slow osc
    input  wire logic       ext_clk_in,           // default external clock
    input  wire logic       sec_xtal_in,          // secondary crystal level
    input  wire logic       clkout_gpio_o,        // gpio value for clock-out
    input  wire logic       clkout_gpio_oe,       // gpio enable for clock-out
    output logic            sys_clk,              // selected system clock
    output logic            clock_in_gpio_mode,   // clock-in pin is gpio
    output logic            clock_out_pin_o,      // clock-out pin value
    output logic            clock_out_pin_oe,     // clock-out pin enable
    output logic            fast_osc_run,         // fast oscillator enabled
    output logic            slow_osc_run          // slow oscillator enabled
);

    // frequency select: 000x slow, else a postscaler tap
    function automatic logic freq_is_slow(input logic [3:0] f);
        return f[3:1] == 3'h0; // RULE4 RULE8
    endfunction

    // tap k means 16 MHz divided by 2**k
    function automatic logic [3:0] freq_tap(input logic [3:0] f);
        logic [3:0] t;
        t = 4'h0;
        case (f)
            4'h2, 4'h3: t = 4'h9;          // 31.25 kHz
            4'h4:       t = 4'h8;          // 62.5 kHz
            4'h5, 4'h8: t = 4'h7;          // 125 kHz  RULE10
            4'h6, 4'h9: t = 4'h6;          // 250 kHz
            4'h7, 4'ha: t = 4'h5;          // 500 kHz
            4'hb:       t = 4'h4;          // 1 MHz
            4'hc:       t = 4'h3;          // 2 MHz
            4'hd:       t = 4'h2;          // 4 MHz
            4'he:       t = 4'h1;          // 8 MHz
            4'hf:       t = 4'h0;          // 16 MHz
            default:    t = 4'h0;
        endcase
        return t; // RULE8
    endfunction

    logic [3:0]           fsel_q;
    logic [1:0]           css_q;
    logic                 sec_en_q;
    logic [7:0]           rdata_q;
    logic [15:0]          fast_cnt_q;
    logic                 fast_lvl_q;
    logic [POST_BITS-1:0] post_q;
    logic [15:0]          slow_cnt_q;
    logic                 slow_lvl_q;
    logic                 slow_ready_q;
    logic                 ext_prev_q;
    logic [10:0]          ost_cnt_q;
    logic                 sec_prev_q;
    logic [10:0]          sec_cnt_q;
    ics_state_t           state_q;
    ics_src_t             cur_src_q;
    logic [3:0]           cur_tap_q;
    ics_src_t             pend_src_q;
    logic [3:0]           pend_tap_q;
    logic                 hold_q;
    logic                 cur_prev_q;
    logic                 new_prev_q;
    logic                 sys_clk_q;
    logic                 clkout_q;

    logic [POST_BITS:0]   taps;
    ics_src_t             tgt_src;
    logic [3:0]           tgt_tap;
    logic                 fast_ready;
    logic                 fast_stable;
    logic                 ost_done;
    logic                 sec_ready;
    logic                 crystal_mode;
    logic                 fast_en;
    logic                 slow_en;
    logic                 cur_lvl;
    logic                 new_lvl;
    logic                 tgt_changed;
    logic                 tgt_is_cur;
    logic                 new_ready;

    // level of a source at a given tap
    function automatic logic src_level(input ics_src_t s,
                                       input logic [3:0] tap,
                                       input logic [POST_BITS:0] tv,
                                       input logic sl, input logic ex,
                                       input logic sc);
        logic l;
        l = 1'b0;
        case (s)
            SRC_EXT:  l = ex;
            SRC_SEC:  l = sc;
            SRC_FAST: l = tv[tap];
            SRC_SLOW: l = sl;
            default:  l = 1'b0;
        endcase
        return l;
    endfunction

    // postscaler taps
    assign taps[0] = fast_lvl_q; // RULE1
    for (genvar k = 1; k <= POST_BITS; k++) begin : g_tap
        assign taps[k] = post_q[k-1];
    end

    assign crystal_mode = (default_osc_config == ICS_CFG_LP) ||
                          (default_osc_config == ICS_CFG_XT) ||
                          (default_osc_config == ICS_CFG_HS);
    assign fast_ready  = fast_cnt_q >= 16'(FAST_START);          // RULE5
    assign fast_stable = fast_cnt_q == 16'(FAST_START + FAST_STAB); // RULE6
    assign ost_done    = ost_cnt_q == 11'(OST_COUNT);
    assign sec_ready   = sec_cnt_q == 11'(SEC_COUNT);

    // target selection
    always_comb begin
        tgt_src = SRC_FAST;
        tgt_tap = freq_tap(fsel_q);
        case (css_q)
            2'b00: begin
                if (default_osc_config != ICS_CFG_INTERNAL_OSC_BLOCK) begin
                    tgt_src = SRC_EXT; // RULE15
                end else if (freq_is_slow(fsel_q)) begin
                    tgt_src = SRC_SLOW;
                end
            end
            2'b01: tgt_src = SRC_SEC; // RULE16
            default: begin
                if (freq_is_slow(fsel_q)) begin
                    tgt_src = SRC_SLOW; // RULE17 RULE2
                end
            end
        endcase
        if (tgt_src != SRC_FAST) begin
            tgt_tap = 4'h0;
        end
    end

    // oscillator enables; current and pending internal sources stay powered
    assign fast_en = (!freq_is_slow(fsel_q) &&
                      (default_osc_config == ICS_CFG_INTERNAL_OSC_BLOCK || css_q[1]))
                     || cur_src_q == SRC_FAST
                     || (state_q != SW_IDLE && pend_src_q == SRC_FAST); // RULE3
    assign slow_en = (freq_is_slow(fsel_q) && css_q[1])
                     || powerup_timer_active || watchdog_enable
                     || failsafe_enable || cur_src_q == SRC_SLOW
                     || (state_q != SW_IDLE && pend_src_q == SRC_SLOW); // RULE4

    // fast oscillator model with start-up and settling counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_cnt_q <= 16'h0;
            fast_lvl_q <= 1'b0;
        end else if (!fast_en) begin
            fast_cnt_q <= 16'h0;
            fast_lvl_q <= 1'b0;
        end else begin
            if (!fast_stable) begin
                fast_cnt_q <= fast_cnt_q + 16'h1; // RULE24
            end
            if (fast_ready) begin
                fast_lvl_q <= ~fast_lvl_q;
            end
        end
    end

    // postscaler counts fast rising edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            post_q <= '0;
        end else if (!fast_en) begin
            post_q <= '0;
        end else if (fast_ready && !fast_lvl_q) begin
            post_q <= post_q + POST_BITS'(1); // RULE1
        end
    end

    // slow oscillator model; ready after its first full cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt_q   <= 16'h0;
            slow_lvl_q   <= 1'b0;
            slow_ready_q <= 1'b0;
        end else if (!slow_en) begin
            slow_cnt_q   <= 16'h0;
            slow_lvl_q   <= 1'b0;
            slow_ready_q <= 1'b0;
        end else if (slow_cnt_q == 16'(SLOW_HALF - 1)) begin
            slow_cnt_q <= 16'h0;
            slow_lvl_q <= ~slow_lvl_q; // RULE2
            if (slow_lvl_q) begin
                slow_ready_q <= 1'b1; // RULE7
            end
        end else begin
            slow_cnt_q <= slow_cnt_q + 16'h1;
        end
    end

    // start-up timer on the external crystal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_q <= 1'b0;
            ost_cnt_q  <= 11'h0;
        end else begin
            ext_prev_q <= ext_clk_in;
            if (!crystal_mode) begin
                ost_cnt_q <= 11'(OST_COUNT);
            end else if (ext_clk_in && !ext_prev_q && !ost_done) begin
                ost_cnt_q <= ost_cnt_q + 11'h1;
            end
        end
    end

    // secondary oscillator gated by its enable bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_prev_q <= 1'b0;
            sec_cnt_q  <= 11'h0;
        end else if (!sec_en_q) begin
            sec_prev_q <= 1'b0;
            sec_cnt_q  <= 11'h0; // RULE21
        end else begin
            sec_prev_q <= sec_xtal_in;
            if (sec_xtal_in && !sec_prev_q && !sec_ready) begin
                sec_cnt_q <= sec_cnt_q + 11'h1;
            end
        end
    end

    assign cur_lvl = src_level(cur_src_q, cur_tap_q, taps, slow_lvl_q,
                               ext_clk_in, sec_xtal_in && sec_en_q);
    assign new_lvl = src_level(pend_src_q, pend_tap_q, taps, slow_lvl_q,
                               ext_clk_in, sec_xtal_in && sec_en_q);
    assign tgt_changed = tgt_src != pend_src_q || tgt_tap != pend_tap_q;
    assign tgt_is_cur  = tgt_src == cur_src_q && tgt_tap == cur_tap_q;

    always_comb begin
        case (pend_src_q)
            SRC_EXT:  new_ready = ost_done;
            SRC_SEC:  new_ready = sec_ready; // RULE22
            SRC_FAST: new_ready = fast_ready;
            SRC_SLOW: new_ready = slow_ready_q;
            default:  new_ready = 1'b0;
        endcase
    end

    // switch sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= SW_IDLE;
            cur_src_q  <= SRC_EXT;
            cur_tap_q  <= 4'h0;
            pend_src_q <= SRC_EXT;
            pend_tap_q <= 4'h0;
            hold_q     <= 1'b0;
        end else begin
            case (state_q)
                SW_IDLE: begin
                    if (!tgt_is_cur) begin
                        pend_src_q <= tgt_src;
                        pend_tap_q <= tgt_tap;
                        state_q    <= SW_START;
                    end
                end
                SW_START: begin
                    if (tgt_changed) begin
                        pend_src_q <= tgt_src; // RULE25
                        pend_tap_q <= tgt_tap;
                    end else if (tgt_is_cur && !hold_q) begin
                        state_q <= SW_IDLE;
                    end else if (new_ready) begin
                        state_q <= hold_q ? SW_RISE : SW_FALL; // RULE11 RULE13
                    end
                end
                SW_FALL: begin
                    if (tgt_changed) begin
                        state_q <= SW_START; // RULE25
                    end else if (cur_prev_q && !cur_lvl) begin
                        hold_q  <= 1'b1; // RULE12
                        state_q <= SW_RISE;
                    end
                end
                SW_RISE: begin
                    if (tgt_changed) begin
                        state_q <= SW_START; // RULE25
                    end else if (new_lvl && !new_prev_q) begin
                        cur_src_q <= pend_src_q; // RULE12 RULE24
                        cur_tap_q <= pend_tap_q;
                        hold_q    <= 1'b0;
                        state_q   <= SW_IDLE;
                    end
                end
                default: state_q <= SW_IDLE;
            endcase
        end
    end

    // edge history and glitch-free output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_prev_q <= 1'b0;
            new_prev_q <= 1'b0;
            sys_clk_q  <= 1'b0;
        end else begin
            cur_prev_q <= cur_lvl;
            new_prev_q <= new_lvl;
            sys_clk_q  <= hold_q ? 1'b0 : cur_lvl; // RULE12
        end
    end

    // register writes; no automatic path touches the source select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fsel_q   <= ICS_FSEL_RESET; // RULE9
            css_q    <= ICS_CSS_RESET;  // RULE18
            sec_en_q <= ICS_T1_RESET[ICS_T1_SEC_EN];
        end else if (reg_wr) begin
            case (reg_addr)
                ICS_ADDR_CTRL: begin
                    fsel_q <= reg_wdata[ICS_FSEL_MSB:ICS_FSEL_LSB];
                    css_q  <= reg_wdata[ICS_CSS_MSB:ICS_CSS_LSB]; // RULE19
                end
                ICS_ADDR_TIMER1_CONTROL_REG: sec_en_q <= reg_wdata[ICS_T1_SEC_EN];
                default: ;
            endcase
        end
    end

    // register reads, data in the following cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= 8'h00;
            case (reg_addr)
                ICS_ADDR_CTRL: begin
                    rdata_q[ICS_FSEL_MSB:ICS_FSEL_LSB] <= fsel_q;
                    rdata_q[ICS_CSS_MSB:ICS_CSS_LSB]   <= css_q;
                end
                ICS_ADDR_STATUS: begin
                    rdata_q[ICS_ST_FAST_STABLE] <= fast_stable;  // RULE14
                    rdata_q[ICS_ST_SLOW_READY]  <= slow_ready_q; // RULE14
                    rdata_q[ICS_ST_FAST_READY]  <= fast_ready;   // RULE14
                    rdata_q[ICS_ST_OST_STATUS]  <= cur_src_q == SRC_EXT
                                                   && ost_done;  // RULE20
                    rdata_q[ICS_ST_BUSY]        <= state_q != SW_IDLE;
                    rdata_q[ICS_ST_SEC_READY]   <= sec_ready;
                end
                ICS_ADDR_TIMER1_CONTROL_REG: rdata_q[ICS_T1_SEC_EN] <= sec_en_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // clock-out pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkout_q <= 1'b0;
        end else begin
            clkout_q <= clock_out_enable ? sys_clk_q : clkout_gpio_o; // RULE23
        end
    end

    assign reg_rdata          = rdata_q;
    assign sys_clk            = sys_clk_q;
    assign clock_in_gpio_mode = cur_src_q == SRC_FAST ||
                                cur_src_q == SRC_SLOW; // RULE23
    assign clock_out_pin_o    = clkout_q;
    assign clock_out_pin_oe   = clock_out_enable | clkout_gpio_oe; // RULE23
    assign fast_osc_run       = fast_en;
    assign slow_osc_run       = slow_en;

endmodule // ics_osc_switch

// >>> ics_osc_switch_asserts.sv
// checker on the ports of the oscillator clock switch
module ics_osc_switch_chk
    import ics_pkg::*;
(
    input wire logic       clk,                  // system clock
    input wire logic       rst_n,                // async reset, low
    input wire logic [1:0] reg_addr,             // register index
    input wire logic [7:0] reg_wdata,            // write data
    input wire logic       reg_wr,               // write strobe
    input wire logic       reg_rd,               // read strobe
    input wire logic [7:0] reg_rdata,            // read data
    input wire logic       clock_out_enable,     // clock-out function
    input wire logic       clkout_gpio_oe,       // gpio enable
    input wire logic       clock_out_pin_oe,     // pin enable
    input wire logic       powerup_timer_active, // timer needs slow osc
    input wire logic       watchdog_enable,      // watchdog needs slow osc
    input wire logic       failsafe_enable,      // monitor needs slow osc
    input wire logic       slow_osc_run,         // slow osc enable
    input wire logic       clock_in_gpio_mode    // clock-in pin is gpio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pin_oe_func: assert property (
        clock_out_pin_oe == (clock_out_enable | clkout_gpio_oe))
        else $error("clock-out pin enable wrong");
    a_slow_for_timers: assert property (
        (powerup_timer_active | watchdog_enable | failsafe_enable)
        |-> slow_osc_run) else $error("slow osc off while needed");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_ctrl_readback: assert property (
        reg_wr && reg_addr == ICS_ADDR_CTRL ##1
        reg_rd && reg_addr == ICS_ADDR_CTRL
        |=> (reg_rdata & 8'h7b) == ($past(reg_wdata, 2) & 8'h7b))
        else $error("control readback wrong");
    a_t1_readback: assert property (
        reg_wr && reg_addr == ICS_ADDR_TIMER1_CONTROL_REG ##1
        reg_rd && reg_addr == ICS_ADDR_TIMER1_CONTROL_REG
        |=> reg_rdata[ICS_T1_SEC_EN] == $past(reg_wdata[ICS_T1_SEC_EN], 2))
        else $error("secondary enable readback wrong");
    a_stable_ready: assert property (
        reg_rd && reg_addr == ICS_ADDR_STATUS
        |=> !reg_rdata[ICS_ST_FAST_STABLE] || reg_rdata[ICS_ST_FAST_READY])
        else $error("stable without ready");
    a_ost_internal: assert property (
        reg_rd && reg_addr == ICS_ADDR_STATUS
        |=> !(reg_rdata[ICS_ST_OST_STATUS] && $past(clock_in_gpio_mode)))
        else $error("start-up status set on internal source");
endmodule // ics_osc_switch_chk

bind ics_osc_switch ics_osc_switch_chk i_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_out_enable(clock_out_enable), .clkout_gpio_oe(clkout_gpio_oe),
    .clock_out_pin_oe(clock_out_pin_oe),
    .powerup_timer_active(powerup_timer_active),
    .watchdog_enable(watchdog_enable), .failsafe_enable(failsafe_enable),
    .slow_osc_run(slow_osc_run), .clock_in_gpio_mode(clock_in_gpio_mode));

// >>> ics_osc_switch_test.sv
// self-checking testbench for the oscillator clock switch
module ics_osc_switch_test
    import ics_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, v, w;
    logic [2:0] cfg = ICS_CFG_LP, div = 0;
    logic coe = 0, pwr = 0, wdt = 0, fsm = 0, gpo = 0, goe = 0, last = 0;
    logic sys_clk, gpio_mode, pin_o, pin_oe, fast_run, slow_run;
    logic [3:0] f, base;
    int n_fail = 0, checked = 0, edges = 0, polls;

    ics_osc_switch #(.SLOW_HALF(4), .OST_COUNT(4), .SEC_COUNT(4))
    i_ics_osc_switch (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .default_osc_config(cfg),
        .clock_out_enable(coe), .powerup_timer_active(pwr),
        .watchdog_enable(wdt), .failsafe_enable(fsm), .ext_clk_in(div[1]),
        .sec_xtal_in(div[2]), .clkout_gpio_o(gpo), .clkout_gpio_oe(goe),
        .sys_clk(sys_clk), .clock_in_gpio_mode(gpio_mode),
        .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
        .fast_osc_run(fast_run), .slow_osc_run(slow_run));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        div <= div + 3'h1;
        last <= sys_clk;
        if (sys_clk !== last) edges++;
    end

    function automatic logic fast_sel(input logic [3:0] s);
        return s[3:1] != 3'h0;
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic op(input logic wr, input logic rd, input logic [1:0] a,
                      input logic [7:0] d);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        op(1'b0, 1'b1, a, 8'h00);
        q = reg_rdata;
    endtask

    // wait for the switch to finish, then watch the clock
    task automatic settle(input int span);
        op(1'b0, 1'b0, 2'h0, 8'h00);
        polls = 0;
        rd(ICS_ADDR_STATUS, v);
        while (v[ICS_ST_BUSY] !== 1'b0 && polls < 2000) begin
            rd(ICS_ADDR_STATUS, v);
            polls++;
        end
        chk({7'h00, v[ICS_ST_BUSY]}, 8'h00);
        op(1'b0, 1'b0, 2'h0, 8'h00);
        edges = 0;
        repeat (span) @(posedge clk);
        #1;
    endtask

    initial begin
        void'($urandom(32'h0a68));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        rd(ICS_ADDR_CTRL, v);
        chk(v, 8'h38);
        rd(ICS_ADDR_TIMER1_CONTROL_REG, v);
        chk(v, ICS_T1_RESET);
        rd(2'h3, v);
        chk(v, 8'h00);
        base = 4'($urandom_range(0, 15));
        for (int k = 0; k < 16; k++) begin
            f = k[3:0] ^ base;
            pwr <= ($urandom_range(0, 3) == 0);
            wdt <= ($urandom_range(0, 3) == 0);
            fsm <= ($urandom_range(0, 3) == 0);
            {coe, goe, gpo} <= 3'($urandom);
            op(1'b1, 1'b0, ICS_ADDR_CTRL, {1'b0, f, 3'b010});
            rd(ICS_ADDR_CTRL, v);
            chk(v & 8'h7b, {1'b0, f, 3'b010});
            settle(600);
            chk({6'h00, fast_run, slow_run},
                {6'h00, fast_sel(f), !fast_sel(f) | pwr | wdt | fsm});
            rd(ICS_ADDR_STATUS, v);
            chk(v & 8'h73, (fast_sel(f) ? 8'h11 : 8'h00)
                | ((!fast_sel(f) | pwr | wdt | fsm) ? 8'h02 : 8'h00));
            chk({7'h00, gpio_mode}, 8'h01);
            chk({7'h00, pin_o}, {7'h00, coe ? last : gpo});
            chk({7'h00, edges != 0}, 8'h01);
        end
        {pwr, wdt, fsm} <= 3'h0;
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h7a);
        settle(100);
        // 16 MHz to 8 MHz: same oscillator, short tap, no start-up wait
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h72);
        settle(10);
        chk({7'h00, polls < 20}, 8'h01);
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h02);
        settle(10);
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h7a);
        op(1'b0, 1'b0, 2'h0, 8'h00);
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h02);
        settle(100);
        rd(ICS_ADDR_STATUS, v);
        chk({fast_run, slow_run, 6'h00} | (v & 8'h13), 8'h42);
        w = v;
        op(1'b1, 1'b0, ICS_ADDR_STATUS, 8'hff);
        rd(ICS_ADDR_STATUS, v);
        chk(v, w);
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h38);
        settle(50);
        rd(ICS_ADDR_STATUS, v);
        chk(v & 8'h20, 8'h20);
        chk({7'h00, gpio_mode}, 8'h00);
        op(1'b1, 1'b0, ICS_ADDR_TIMER1_CONTROL_REG, 8'h08);
        rd(ICS_ADDR_TIMER1_CONTROL_REG, v);
        chk(v & 8'h08, 8'h08);
        polls = 0;
        while (v[ICS_ST_SEC_READY] !== 1'b1 && polls < 500) begin
            rd(ICS_ADDR_STATUS, v);
            polls++;
        end
        chk({7'h00, v[ICS_ST_SEC_READY]}, 8'h01);
        op(1'b1, 1'b0, ICS_ADDR_CTRL, 8'h39);
        settle(100);
        rd(ICS_ADDR_STATUS, v);
        chk(v & 8'h20, 8'h00);
        chk({7'h00, edges != 0}, 8'h01);
        finish_test();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule // ics_osc_switch_test

// >>> ics_pkg.sv
// ics_pkg: constants and types for the internal oscillator clock switch
package ics_pkg;

    // register map (word index on the plain register port)
    localparam logic [1:0] ICS_ADDR_CTRL   = 2'h0; // osc_control_reg
    localparam logic [1:0] ICS_ADDR_STATUS = 2'h1; // osc_status_reg
    localparam logic [1:0] ICS_ADDR_TIMER1_CONTROL_REG  = 2'h2; // timer1_control_reg

    // osc_control_reg fields
    localparam int         ICS_FSEL_LSB    = 3;
    localparam int         ICS_FSEL_MSB    = 6;
    localparam int         ICS_CSS_LSB     = 0;
    localparam int         ICS_CSS_MSB     = 1;
    localparam logic [3:0] ICS_FSEL_RESET  = 4'h7; // 500 kHz
    localparam logic [1:0] ICS_CSS_RESET   = 2'h0;

    // osc_status_reg fields
    localparam int ICS_ST_FAST_STABLE = 0;
    localparam int ICS_ST_SLOW_READY  = 1;
    localparam int ICS_ST_FAST_READY  = 4;
    localparam int ICS_ST_OST_STATUS  = 5;
    localparam int ICS_ST_BUSY        = 6;
    localparam int ICS_ST_SEC_READY   = 7;

    // timer1_control_reg field
    localparam int         ICS_T1_SEC_EN  = 3;
    localparam logic [7:0] ICS_T1_RESET   = 8'h00;

    // default_osc_config codes
    localparam logic [2:0] ICS_CFG_LP     = 3'h0;
    localparam logic [2:0] ICS_CFG_XT     = 3'h1;
    localparam logic [2:0] ICS_CFG_HS     = 3'h2;
    localparam logic [2:0] ICS_CFG_INTERNAL_OSC_BLOCK = 3'h4;

    // timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int FAST_OSC_HZ     = 16_000_000;
    localparam int SLOW_OSC_HZ     = 31_000;
    localparam int FAST_START_NS   = 2000;
    localparam int FAST_START_CYC  = (FAST_START_NS * (CLK_HZ / 1_000_000)
                                      + 999) / 1000;
    localparam int FAST_STABLE_CYC = 64;
    localparam int FAST_HALF_CYC   = 1;  // model runs below 16 MHz
    localparam int SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_OSC_HZ);
    localparam int OST_EDGES       = 1024;
    localparam int SEC_READY_EDGES = 1024;
    localparam int POST_BITS       = 9;  // 16 MHz down to 31.25 kHz

    typedef enum logic [1:0] {
        SRC_EXT, SRC_SEC, SRC_FAST, SRC_SLOW
    } ics_src_t;

    typedef enum logic [1:0] {
        SW_IDLE, SW_START, SW_FALL, SW_RISE
    } ics_state_t;

endpackage
